// [ufr_pkg.sv]
// Constants for the undervoltage response and phased overcurrent limit block.
// Assumes a command port that delivers whole byte and word writes in one cycle.
package ufr_pkg;

    // ==========================================================
    // Command codes and phase selector
    localparam logic [7:0]  CMD_UV_ACTION   = 8'h45;
    localparam logic [7:0]  CMD_OC_LIMIT    = 8'h46;
    localparam logic [7:0]  PHASE_ALL       = 8'hFF;

    // ==========================================================
    // Undervoltage action byte layout and codes
    localparam int          UV_ACT_LSB      = 6;
    localparam int          UV_RETRY_LSB    = 3;
    localparam int          UV_DLY_LSB      = 0;
    localparam logic [1:0]  ACT_IGNORE      = 2'h0;
    localparam logic [1:0]  ACT_DELAYED     = 2'h1;
    localparam logic [1:0]  ACT_IMMEDIATE   = 2'h2;
    localparam logic [2:0]  RETRY_NONE      = 3'h0;
    localparam logic [2:0]  RETRY_FOREVER   = 3'h7;
    localparam logic [7:0]  UV_ACTION_RESET = 8'h80;

    // ==========================================================
    // Shutdown delays in switching clock periods
    localparam logic [3:0]  DLY_SHORT       = 4'h3;
    localparam logic [3:0]  DLY_MID         = 4'h5;
    localparam logic [3:0]  DLY_LONG        = 4'h9;

    // ==========================================================
    // Overcurrent limit word layout; currents held in 1/16 A
    localparam int          OC_EXP_LSB      = 11;
    localparam logic [4:0]  OC_EXP_READ     = 5'h1E;
    localparam logic [4:0]  OC_EXP_FINE     = 5'h1C;
    localparam int          FRAC_SHIFT      = 4;
    localparam int          STACK_MAX_A     = 62;
    localparam int          PHASE_MAX_A     = 23;
    localparam int          HW_MIN_A        = 4;
    localparam logic [9:0]  OC_LIMIT_RESET  = 10'h0A0;

    typedef enum logic [2:0] {
        ST_OFF, ST_START, ST_RUN, ST_DELAY, ST_HICCUP, ST_LATCH
    } ufr_state_type;

endpackage

// [ufr_core.sv]
// Undervoltage fault response sequencer and phased overcurrent limit bank.
// Assumes a one-cycle command port, a switching tick pulse and synchronous inputs.
module ufr_core #(
    parameter int PHASES_MAX = 4
) (
    // Clock and reset
    input  wire logic        clock_i,
    input  wire logic        arst_n_i,
    // Command port
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    input  wire logic [7:0]  cmd_i,
    input  wire logic [15:0] wdata_i,
    input  wire logic [7:0]  phase_sel_i,
    output logic      [15:0] rd_data_o,
    output logic             rd_valid_o,
    // Stack and power stage
    input  wire logic [2:0]  phase_count_i,
    input  wire logic [1:0]  own_phase_i,
    input  wire logic        output_on_i,
    input  wire logic        uv_fault_i,
    input  wire logic        startup_done_i,
    input  wire logic        pwm_tick_i,
    input  wire logic [15:0] soft_start_rise_time_i,
    input  wire logic [11:0] iout_i,
    input  wire logic        nvm_restore_i,
    output logic             stage_enable_o,
    output logic             oc_trip_o,
    output logic      [4:0]  oc_hw_amps_o,
    // Status
    input  wire logic        clear_faults_i,
    output logic             uv_fault_status_o,
    output logic             vout_word_bit_o,
    output logic             data_fault_o,
    output logic             notify_o
);

    if (PHASES_MAX < 1 || PHASES_MAX > 4) begin : g_bad_phases
        $error("PHASES_MAX must be 1 to 4");
    end

    // ==========================================================
    // Helpers
    function automatic int lin_to_s16(input logic [15:0] w);
        int m;
        int s;
        m = int'($signed(w[10:0]));
        s = int'($signed(w[15:11])) + ufr_pkg::FRAC_SHIFT;
        if (m < 0) return -1;
        if (s >= 0) return (s > 12) ? ((m == 0) ? 0 : -1) : (m << s);
        if (s < -15) return (m == 0) ? 0 : 1;
        return (m + (1 << (-s)) - 1) >>> (-s);
    endfunction

    function automatic logic [3:0] delay_ticks(input logic [2:0] d);
        if (d <= 3'h1) return ufr_pkg::DLY_SHORT;
        if (d <= 3'h4) return ufr_pkg::DLY_MID;
        return ufr_pkg::DLY_LONG;
    endfunction

    function automatic logic [2:0] hiccup_mult(input logic [2:0] d);
        return (d <= 3'h1) ? 3'h1 : d;
    endfunction

    function automatic logic [4:0] hw_amps(input logic [9:0] v);
        logic [5:0] a;
        a = 6'((v + 10'hF) >> ufr_pkg::FRAC_SHIFT);
        if (a < 6'(ufr_pkg::HW_MIN_A)) a = 6'(ufr_pkg::HW_MIN_A);
        if (a > 6'(ufr_pkg::PHASE_MAX_A)) a = 6'(ufr_pkg::PHASE_MAX_A);
        return a[4:0];
    endfunction

    // ==========================================================
    // Register bank
    logic [7:0]  uv_action_r;
    logic [9:0]  limit_r [PHASES_MAX];
    logic [1:0]  uv_act;
    logic [2:0]  uv_restart_count;
    logic [2:0]  uv_delay_select;
    int          wr_val;
    int          per_phase;
    int          nph;
    logic        bad_uv_wr;
    logic        bad_oc_wr;
    logic [1:0]  sel_idx;

    // Limits read back in quarter amps, so a whole-stack value still fits the mantissa.
    localparam int         READ_SHIFT = ufr_pkg::FRAC_SHIFT + int'($signed(ufr_pkg::OC_EXP_READ));
    localparam logic [9:0] NVM_MAX_Q  = 10'(ufr_pkg::PHASE_MAX_A << ufr_pkg::FRAC_SHIFT);

    assign uv_act           = uv_action_r[ufr_pkg::UV_ACT_LSB +: 2];
    assign uv_restart_count = uv_action_r[ufr_pkg::UV_RETRY_LSB +: 3];
    assign uv_delay_select  = uv_action_r[ufr_pkg::UV_DLY_LSB +: 3];
    assign sel_idx          = phase_sel_i[1:0];

    always_comb begin
        nph       = (phase_count_i == 3'h0) ? 1 : int'(phase_count_i);
        wr_val    = lin_to_s16(wdata_i);
        per_phase = wr_val / nph;
        bad_uv_wr = wdata_i[ufr_pkg::UV_ACT_LSB +: 2] == 2'h3;
        if (wr_val < 0) begin
            bad_oc_wr = 1'b1;
        end else if (phase_sel_i == ufr_pkg::PHASE_ALL) begin
            bad_oc_wr = wr_val > ((ufr_pkg::STACK_MAX_A * nph) << ufr_pkg::FRAC_SHIFT);
        end else begin
            bad_oc_wr = (wr_val > (ufr_pkg::PHASE_MAX_A << ufr_pkg::FRAC_SHIFT))
                     || (int'(sel_idx) >= nph) || (phase_sel_i[7:2] != 6'h00);
        end
    end

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            uv_action_r <= ufr_pkg::UV_ACTION_RESET;
        end else if (wr_i && cmd_i == ufr_pkg::CMD_UV_ACTION && !bad_uv_wr) begin
            uv_action_r <= wdata_i[7:0];
        end
    end

    for (genvar p = 0; p < PHASES_MAX; p++) begin : g_limit
        always_ff @(posedge clock_i or negedge arst_n_i) begin
            if (!arst_n_i) begin
                limit_r[p] <= ufr_pkg::OC_LIMIT_RESET;
            end else if (wr_i && cmd_i == ufr_pkg::CMD_OC_LIMIT && !bad_oc_wr) begin
                if (phase_sel_i == ufr_pkg::PHASE_ALL) begin
                    limit_r[p] <= 10'(per_phase);
                end else if (int'(sel_idx) == p) begin
                    limit_r[p] <= 10'(wr_val);
                end
            end else if (nvm_restore_i && limit_r[p] > NVM_MAX_Q) begin
                limit_r[p] <= NVM_MAX_Q;
            end else if (nvm_restore_i) begin
                limit_r[p] <= (limit_r[p] + 10'h2) & 10'h3FC;
            end
        end
    end

    // Read answer one cycle after the strobe.
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rd_data_o  <= 16'h0000;
            rd_valid_o <= 1'b0;
        end else begin
            rd_valid_o <= rd_i;
            if (rd_i && cmd_i == ufr_pkg::CMD_UV_ACTION) begin
                rd_data_o <= {8'h00, uv_action_r};
            end else if (rd_i && cmd_i == ufr_pkg::CMD_OC_LIMIT) begin
                if (phase_sel_i == ufr_pkg::PHASE_ALL) begin
                    rd_data_o <= {ufr_pkg::OC_EXP_READ,
                                  11'((limit_r[0] * nph) >> READ_SHIFT)};
                end else begin
                    rd_data_o <= {ufr_pkg::OC_EXP_READ,
                                  11'(limit_r[sel_idx] >> READ_SHIFT)};
                end
            end else if (rd_i) begin
                rd_data_o <= 16'h0000;
            end
        end
    end

    // ==========================================================
    // Overcurrent comparison for this device's own phase
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            oc_hw_amps_o <= 5'h00;
            oc_trip_o    <= 1'b0;
        end else begin
            oc_hw_amps_o <= hw_amps(limit_r[own_phase_i]);
            oc_trip_o    <= iout_i > {3'h0, oc_hw_amps_o, 4'h0};
        end
    end

    // ==========================================================
    // Undervoltage response sequencer
    ufr_pkg::ufr_state_type state_r;
    logic [3:0]  dly_cnt_r;
    logic [15:0] rise_cnt_r;
    logic [2:0]  mult_cnt_r;
    logic [2:0]  attempts_r;
    logic        give_up;

    assign give_up = (uv_restart_count == ufr_pkg::RETRY_NONE)
                  || (uv_restart_count != ufr_pkg::RETRY_FOREVER
                      && attempts_r >= uv_restart_count);

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_r    <= ufr_pkg::ST_OFF;
            dly_cnt_r  <= 4'h0;
            rise_cnt_r <= 16'h0000;
            mult_cnt_r <= 3'h0;
            attempts_r <= 3'h0;
        end else if (!output_on_i) begin
            state_r    <= ufr_pkg::ST_OFF;
            attempts_r <= 3'h0;
        end else begin
            unique case (state_r)
                ufr_pkg::ST_OFF: state_r <= ufr_pkg::ST_START;
                ufr_pkg::ST_START, ufr_pkg::ST_RUN: begin
                    if (uv_fault_i && uv_act == ufr_pkg::ACT_DELAYED) begin
                        state_r   <= ufr_pkg::ST_DELAY;
                        dly_cnt_r <= delay_ticks(uv_delay_select);
                    end else if (uv_fault_i && uv_act == ufr_pkg::ACT_IMMEDIATE) begin
                        state_r    <= give_up ? ufr_pkg::ST_LATCH
                                              : ufr_pkg::ST_HICCUP;
                        rise_cnt_r <= soft_start_rise_time_i;
                        mult_cnt_r <= hiccup_mult(uv_delay_select);
                    end else if (state_r == ufr_pkg::ST_START && startup_done_i) begin
                        state_r    <= ufr_pkg::ST_RUN;
                        attempts_r <= 3'h0;
                    end
                end
                ufr_pkg::ST_DELAY: begin
                    if (pwm_tick_i && dly_cnt_r <= 4'h1) begin
                        state_r    <= give_up ? ufr_pkg::ST_LATCH : ufr_pkg::ST_HICCUP;
                        rise_cnt_r <= soft_start_rise_time_i;
                        mult_cnt_r <= hiccup_mult(uv_delay_select);
                    end else if (pwm_tick_i) begin
                        dly_cnt_r <= dly_cnt_r - 4'h1;
                    end
                end
                ufr_pkg::ST_HICCUP: begin
                    if (rise_cnt_r > 16'h0001) begin
                        rise_cnt_r <= rise_cnt_r - 16'h0001;
                    end else if (mult_cnt_r > 3'h1) begin
                        rise_cnt_r <= soft_start_rise_time_i;
                        mult_cnt_r <= mult_cnt_r - 3'h1;
                    end else begin
                        state_r <= ufr_pkg::ST_START;
                        if (attempts_r != 3'h7) attempts_r <= attempts_r + 3'h1;
                    end
                end
                ufr_pkg::ST_LATCH: state_r <= ufr_pkg::ST_LATCH;
            endcase
        end
    end

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            stage_enable_o <= 1'b0;
        end else begin
            stage_enable_o <= output_on_i
                && (state_r == ufr_pkg::ST_START || state_r == ufr_pkg::ST_RUN
                    || state_r == ufr_pkg::ST_DELAY);
        end
    end

    // ==========================================================
    // Sticky status; a new event wins over a clear in the same cycle.
    logic uv_event;
    logic data_event;

    assign uv_event   = uv_fault_i && (state_r == ufr_pkg::ST_RUN || state_r == ufr_pkg::ST_START);
    assign data_event = wr_i && ((cmd_i == ufr_pkg::CMD_UV_ACTION && bad_uv_wr)
                              || (cmd_i == ufr_pkg::CMD_OC_LIMIT && bad_oc_wr));

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            uv_fault_status_o <= 1'b0;
            vout_word_bit_o   <= 1'b0;
            data_fault_o      <= 1'b0;
            notify_o          <= 1'b0;
        end else begin
            uv_fault_status_o <= uv_event || (uv_fault_status_o && !clear_faults_i);
            vout_word_bit_o   <= uv_event || (vout_word_bit_o && !clear_faults_i);
            data_fault_o      <= data_event || (data_fault_o && !clear_faults_i);
            notify_o          <= uv_event || data_event || (notify_o && !clear_faults_i);
        end
    end

    // ==========================================================
    // Checks
    chk_ignore_runs: assert property (@(posedge clock_i) disable iff (!arst_n_i)
        state_r == ufr_pkg::ST_RUN && uv_act == ufr_pkg::ACT_IGNORE && output_on_i
        |=> state_r == ufr_pkg::ST_RUN) else $error("ignore action left run");
    chk_delay_path: assert property (@(posedge clock_i) disable iff (!arst_n_i)
        state_r == ufr_pkg::ST_RUN && uv_fault_i && output_on_i && uv_act == ufr_pkg::ACT_DELAYED
        |=> state_r == ufr_pkg::ST_DELAY) else $error("delayed action not taken");
    chk_immediate_off: assert property (@(posedge clock_i) disable iff (!arst_n_i)
        state_r == ufr_pkg::ST_RUN && uv_fault_i && output_on_i
        && uv_act == ufr_pkg::ACT_IMMEDIATE |=> ##1 !stage_enable_o) else $error("no shutdown");
    chk_bad_action: assert property (@(posedge clock_i) disable iff (!arst_n_i)
        wr_i && cmd_i == ufr_pkg::CMD_UV_ACTION && wdata_i[7:6] == 2'h3
        |=> $stable(uv_action_r) && data_fault_o) else $error("bad action accepted");
    chk_no_retry: assert property (@(posedge clock_i) disable iff (!arst_n_i)
        state_r == ufr_pkg::ST_DELAY && uv_restart_count == 3'h0 && pwm_tick_i
        && dly_cnt_r <= 4'h1 && output_on_i |=> state_r == ufr_pkg::ST_LATCH)
        else $error("retry zero did not latch");
    chk_delay_load: assert property (@(posedge clock_i) disable iff (!arst_n_i)
        $rose(state_r == ufr_pkg::ST_DELAY) |-> dly_cnt_r == (uv_delay_select < 3'h2 ? 4'h3
        : uv_delay_select < 3'h5 ? 4'h5 : 4'h9)) else $error("wrong delay count");
    chk_bad_limit: assert property (@(posedge clock_i) disable iff (!arst_n_i)
        wr_i && cmd_i == ufr_pkg::CMD_OC_LIMIT && wdata_i[10]
        |=> data_fault_o && $stable(limit_r[0])) else $error("negative limit accepted");
    chk_hw_floor: assert property (@(posedge clock_i) disable iff (!arst_n_i)
        $past(arst_n_i) |-> oc_hw_amps_o >= 5'h04 && oc_hw_amps_o <= 5'h17)
        else $error("hw limit out of range");
    chk_uv_status: assert property (@(posedge clock_i) disable iff (!arst_n_i)
        uv_event |=> uv_fault_status_o && vout_word_bit_o && notify_o)
        else $error("uv status not set");
    chk_off_clears: assert property (@(posedge clock_i) disable iff (!arst_n_i)
        !output_on_i |=> attempts_r == 3'h0) else $error("attempts not cleared");

endmodule // ufr_core

// [ufr_host_model.sv]
// Host side model: issues byte and word commands on the command port.
// Assumes the device takes a one-cycle strobe and answers a read one cycle later.
module ufr_host_model (
    // Clock
    input  wire logic        clock_i,
    // Command port
    output logic             wr_o,
    output logic             rd_o,
    output logic      [7:0]  cmd_o,
    output logic      [15:0] wdata_o,
    output logic      [7:0]  phase_sel_o,
    input  wire logic [15:0] rd_data_i,
    input  wire logic        rd_valid_i
);
    timeunit 1ns;
    timeprecision 1ps;

    // ==========================================================
    // Bus cycles
    initial begin
        wr_o        = 1'b0;
        rd_o        = 1'b0;
        cmd_o       = 8'h00;
        wdata_o     = 16'h0000;
        phase_sel_o = 8'h00;
    end

    // Released cmd and data lines show the inverse of their last value; the phase select keeps its stale copy.
    task automatic issue(input logic wr, input logic [7:0] cmd, input logic [7:0] sel,
                         input logic [15:0] data);
        @(posedge clock_i);
        wr_o        <= wr;
        rd_o        <= ~wr;
        cmd_o       <= cmd;
        phase_sel_o <= sel;
        wdata_o     <= data;
        @(posedge clock_i);
        wr_o        <= 1'b0;
        rd_o        <= 1'b0;
        cmd_o       <= ~cmd;
        wdata_o     <= ~data;
    endtask

    task automatic read(input logic [7:0] cmd, input logic [7:0] sel,
                        output logic [15:0] data, output logic ok);
        issue(1'b0, cmd, sel, 16'h0000);
        @(negedge clock_i);
        ok   = (rd_valid_i === 1'b1);
        data = rd_data_i;
    endtask
endmodule // ufr_host_model

// [tb_top.sv]
// Self-checking bench for the undervoltage response and overcurrent limit block.
// Assumes ufr_pkg, ufr_core and ufr_host_model are compiled ahead of this file.
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    // ==========================================================
    // Signals and instances
    localparam int RISE = 8;
    logic        clk;
    logic        arst_n = 1'b0;
    logic        on = 1'b0, uv = 1'b0, su_done = 1'b0, tick = 1'b0, nvm = 1'b0, clr = 1'b0;
    logic [11:0] iout   = 12'h000;
    logic        wr, rd, rvalid, stage_en, trip, uv_st, vw_bit, dfault, notify;
    logic [7:0]  cmd, sel;
    logic [15:0] wdata, rdata;
    logic [4:0]  hw_a;
    int          n_mismatch = 0;
    int          compares   = 0;

    ufr_host_model host_u (.clock_i(clk), .wr_o(wr), .rd_o(rd), .cmd_o(cmd), .wdata_o(wdata),
        .phase_sel_o(sel), .rd_data_i(rdata), .rd_valid_i(rvalid));
    ufr_core #(.PHASES_MAX(4)) dut_u (
        .clock_i(clk), .arst_n_i(arst_n), .wr_i(wr), .rd_i(rd), .cmd_i(cmd),
        .wdata_i(wdata), .phase_sel_i(sel), .rd_data_o(rdata), .rd_valid_o(rvalid),
        .phase_count_i(3'h4), .own_phase_i(2'h1), .output_on_i(on), .uv_fault_i(uv),
        .startup_done_i(su_done), .pwm_tick_i(tick), .soft_start_rise_time_i(16'h0008),
        .iout_i(iout), .nvm_restore_i(nvm), .stage_enable_o(stage_en), .oc_trip_o(trip),
        .oc_hw_amps_o(hw_a), .clear_faults_i(clr), .uv_fault_status_o(uv_st),
        .vout_word_bit_o(vw_bit), .data_fault_o(dfault), .notify_o(notify));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // ==========================================================
    // Shared tasks
    task automatic close_out();
        if (n_mismatch == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic check_word(input string what, input logic [15:0] exp, input logic [15:0] got);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic check_bit(input string what, input logic exp, input logic got);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error %s expected %b seen %b", what, exp, got);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    // Counts low-to-high or high-to-low time of the stage enable; a stuck level ends the run.
    task automatic wait_stage(input logic lvl, input int lim, output int n);
        n = 0;
        while (stage_en !== lvl) begin
            @(negedge clk);
            n++;
            if (n > lim) begin
                n_mismatch++;
                $display("Error stage_enable expected %b seen %b", lvl, stage_en);
                close_out();
            end
        end
    endtask
    task automatic rd_chk(input logic [7:0] c, input logic [7:0] s, input logic [15:0] exp);
        logic [15:0] got;
        logic        ok;
        host_u.read(c, s, got, ok);
        check_bit("rd_valid", 1'b1, ok);
        check_word("rd_data", exp, got);
    endtask
    task automatic wr_cmd(input logic [7:0] c, input logic [7:0] s, input logic [15:0] d);
        host_u.issue(1'b1, c, s, d);
        cyc(2);
    endtask
    task automatic clear_flags();
        @(posedge clk) clr <= 1'b1;
        @(posedge clk) clr <= 1'b0;
        cyc(1);
        check_bit("data_fault_clear", 1'b0, dfault);
    endtask
    task automatic refuse(input logic [7:0] c, input logic [7:0] s, input logic [15:0] d);
        clear_flags();
        wr_cmd(c, s, d);
        check_bit("data_fault", 1'b1, dfault);
        check_bit("notify", 1'b1, notify);
    endtask
    task automatic start_ok();
        @(posedge clk) su_done <= 1'b1;
        @(posedge clk) su_done <= 1'b0;
        cyc(1);
    endtask
    task automatic bring_up();
        int n;
        @(posedge clk) on <= 1'b1;
        wait_stage(1'b1, 6, n);
        start_ok();
    endtask
    task automatic power_off();
        @(posedge clk) on <= 1'b0;
        cyc(4);
    endtask
    task automatic uv_pulse();
        @(posedge clk) uv <= 1'b1;
        @(posedge clk) uv <= 1'b0;
    endtask
    task automatic tick_n(input int n);
        repeat (n) begin
            @(posedge clk) tick <= 1'b1;
            @(posedge clk) tick <= 1'b0;
        end
        cyc(2);
    endtask

    // ==========================================================
    // Scenarios
    task automatic sc_regs();
        rd_chk(8'h45, 8'hFF, 16'h0080);
        rd_chk(8'h46, 8'h00, 16'hF028);
        rd_chk(8'h47, 8'h00, 16'h0000);
        check_word("hw_amps", 16'h000A, {11'h000, hw_a});
        wr_cmd(8'h46, 8'hFF, 16'hF0C0);
        rd_chk(8'h46, 8'hFF, 16'hF0C0);
        rd_chk(8'h46, 8'h02, 16'hF030);
        wr_cmd(8'h46, 8'h01, 16'hF015);
        rd_chk(8'h46, 8'h01, 16'hF015);
        rd_chk(8'h46, 8'h00, 16'hF030);
        check_word("hw_amps", 16'h0006, {11'h000, hw_a});
        @(posedge clk) iout <= 12'h060;
        cyc(3);
        check_bit("oc_trip", 1'b0, trip);
        @(posedge clk) iout <= 12'h061;
        cyc(3);
        check_bit("oc_trip", 1'b1, trip);
        @(posedge clk) iout <= 12'h000;
        wr_cmd(8'h46, 8'h01, 16'hF008);
        rd_chk(8'h46, 8'h01, 16'hF008);
        check_word("hw_amps", 16'h0004, {11'h000, hw_a});
        wr_cmd(8'h46, 8'h01, 16'hE057);
        @(posedge clk) nvm <= 1'b1;
        @(posedge clk) nvm <= 1'b0;
        rd_chk(8'h46, 8'h01, 16'hF016);
        wr_cmd(8'h46, 8'hFF, 16'h00F8);
        check_bit("data_fault", 1'b0, dfault);
        check_word("hw_amps", 16'h0017, {11'h000, hw_a});
        rd_chk(8'h46, 8'hFF, 16'hF3E0);
        @(posedge clk) nvm <= 1'b1;
        @(posedge clk) nvm <= 1'b0;
        rd_chk(8'h46, 8'h01, 16'hF05C);
    endtask

    task automatic sc_refuse();
        refuse(8'h45, 8'h00, 16'h00C0);
        rd_chk(8'h45, 8'hFF, 16'h0080);
        refuse(8'h46, 8'hFF, 16'h00FC);
        refuse(8'h46, 8'h01, 16'hF05D);
        refuse(8'h46, 8'h01, 16'hF7FF);
        refuse(8'h46, 8'h04, 16'hF020);
        rd_chk(8'h46, 8'h01, 16'hF05C);
    endtask

    task automatic sc_latch();
        int n;
        bring_up();
        uv_pulse();
        wait_stage(1'b0, 4, n);
        check_bit("uv_status", 1'b1, uv_st);
        check_bit("vout_word", 1'b1, vw_bit);
        cyc(40);
        check_bit("stage_latched", 1'b0, stage_en);
        power_off();
        wr_cmd(8'h45, 8'h00, 16'h0088);
        bring_up();
        for (int i = 0; i < 3; i++) begin
            uv_pulse();
            wait_stage(1'b0, 4, n);
            wait_stage(1'b1, RISE + 6, n);
            check_bit("hiccup_time", 1'b1, n >= RISE);
            if (i < 2) start_ok();
        end
        uv_pulse();
        wait_stage(1'b0, 4, n);
        cyc(40);
        check_bit("stage_latched", 1'b0, stage_en);
        power_off();
        wr_cmd(8'h45, 8'h00, 16'h0040);
        bring_up();
        @(posedge clk) uv <= 1'b1;
        tick_n(3);
        @(posedge clk) uv <= 1'b0;
        cyc(40);
        check_bit("stage_latched", 1'b0, stage_en);
        power_off();
    endtask

    task automatic sc_delay();
        int         n;
        logic [2:0] dly [3]   = '{3'h1, 3'h3, 3'h6};
        int         ticks [3] = '{3, 5, 9};
        int         mult [3]  = '{1, 3, 6};
        for (int k = 0; k < 3; k++) begin
            wr_cmd(8'h45, 8'h00, {8'h00, 2'h1, 3'h7, dly[k]});
            bring_up();
            repeat (2) begin
                @(posedge clk) uv <= 1'b1;
                tick_n(ticks[k] - 1);
                check_bit("stage_in_delay", 1'b1, stage_en);
                @(posedge clk) tick <= 1'b1;
                @(posedge clk) begin
                    tick <= 1'b0;
                    uv   <= 1'b0;
                end
                wait_stage(1'b0, 4, n);
                wait_stage(1'b1, mult[k] * RISE + 6, n);
                check_bit("hiccup_time", 1'b1, n >= mult[k] * RISE);
            end
            power_off();
        end
    endtask

    task automatic sc_ignore();
        wr_cmd(8'h45, 8'h00, 16'h0038);
        clear_flags();
        bring_up();
        @(posedge clk) uv <= 1'b1;
        tick_n(12);
        check_bit("stage_enable", 1'b1, stage_en);
        check_bit("uv_status", 1'b1, uv_st);
        check_bit("notify", 1'b1, notify);
        @(posedge clk) uv <= 1'b0;
        power_off();
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        repeat (16) @(posedge clk);
        arst_n <= 1'b1;
        cyc(2);
        sc_regs();
        sc_refuse();
        sc_latch();
        sc_delay();
        sc_ignore();
        close_out();
    end
endmodule // tb_top
